// ==== rtl/ser_cfg.svh ====
// Bit positions, masks and reset values of the status reporting block
`ifndef SER_CFG_SVH
`define SER_CFG_SVH

`define SER_STB_SCAN_IDLE            0
`define SER_STB_INTERFACE_READY      1
`define SER_STB_ERROR_SUMMARY        2
`define SER_STB_MEASUREMENT_SUMMARY  3
`define SER_STB_MSG_AVAILABLE        4
`define SER_STB_EVENT_SUMMARY        5
`define SER_STB_SERVICE_REQ          6
`define SER_STB_SRQ_SOURCES          8'h3F

`define SER_ESR_RX_OVERFLOW          0
`define SER_ESR_TX_OVERFLOW          2
`define SER_ESR_EXECUTION_ERROR      4
`define SER_ESR_ILLEGAL_CMD          5
`define SER_ESR_USER_REQUEST         6
`define SER_ESR_POWER_ON_EVENT       7
`define SER_ESR_USED                 8'hF5

`define SER_MEAS_REF_UNLOCK          0
`define SER_MEAS_REF_FREQ_RANGE      1
`define SER_MEAS_STORAGE_TRIGGER     3
`define SER_MEAS_INPUT_OVERLOAD      4
`define SER_MEAS_IF_AMP_OVERLOAD     5
`define SER_MEAS_FILTER_OVERLOAD     6
`define SER_MEAS_REF_FREQ_CHANGED    7
`define SER_MEAS_CHAN_ONE_OVERLOAD   8
`define SER_MEAS_CHAN_TWO_OVERLOAD   9
`define SER_MEAS_AUX_OVERLOAD        10
`define SER_MEAS_RATIO_UNDERFLOW     11
`define SER_MEAS_USED                16'h0FFB

`define SER_ERR_BATTERY_FAIL         1
`define SER_ERR_RAM_TEST_FAIL        2
`define SER_ERR_LOGIC_TEST_FAIL      3
`define SER_ERR_ROM_TEST_FAIL        4
`define SER_ERR_FAST_XFER_ABORT      5
`define SER_ERR_DSP_TEST_FAIL        6
`define SER_ERR_MATH_ERROR           7
`define SER_ERR_USED                 8'hFE

`define SER_ENABLE_RESET             16'h0000
`define SER_LATCH_RESET              1'b0

`endif

// ==== rtl/ser_pkg.sv ====
// Types shared by the status reporting block
package ser_pkg;

  typedef enum logic [2:0] {
    SEL_STB  = 3'b000,
    SEL_SRE  = 3'b001,
    SEL_ESR  = 3'b010,
    SEL_ESE  = 3'b011,
    SEL_MEAS = 3'b100,
    SEL_MEAE = 3'b101,
    SEL_ERR  = 3'b110,
    SEL_ERRE = 3'b111
  } ser_sel_t;

endpackage : ser_pkg

// ==== rtl/ser_latch_reg.sv ====
// Sticky event register with per-bit clear, unused bits tied low
`timescale 1ns/1ps
`include "ser_cfg.svh"

module ser_latch_reg
  import ser_pkg::*;
#(
  parameter int                 WIDTH = 8,
  parameter logic [WIDTH-1:0]   USED  = '1
)(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] setVec,
  input  wire logic [WIDTH-1:0] clearVec,
  output logic [WIDTH-1:0]      value
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : gBit
      if (USED[g])
      begin : gLive
        logic bitQ;
        // Set wins over a clear in the same cycle
        always_ff @(posedge ref_clk or posedge rst)
        begin
          if (rst)
            bitQ <= `SER_LATCH_RESET;
          else
            bitQ <= setVec[g] | (bitQ & ~clearVec[g]);
        end
        assign value[g] = bitQ;
      end
      else
      begin : gDead
        assign value[g] = 1'b0;
      end
    end
  endgenerate

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  setWins_a : assert property ((setVec & USED) != '0 |=> (value & $past(setVec & USED)) == $past(setVec & USED))
    else $error("latched event lost");

endmodule : ser_latch_reg

// ==== rtl/ser_srq_gen.sv ====
// Service request: rising edge of an enabled summary bit, cleared by poll
`timescale 1ns/1ps
`include "ser_cfg.svh"

module ser_srq_gen
  import ser_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [7:0] summaryBits,
  input  wire logic [7:0] enableBits,
  input  wire logic       serialPoll,
  output logic            srqPending
);

  logic [7:0] enabledNow;
  logic [7:0] enabledPrev;
  logic       rising;

  assign enabledNow = summaryBits & enableBits & `SER_STB_SRQ_SOURCES;
  assign rising     = |(enabledNow & ~enabledPrev);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      enabledPrev <= 8'h00;
    else
      enabledPrev <= enabledNow;
  end

  // A fresh request in the poll cycle survives the poll
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      srqPending <= 1'b0;
    else
      srqPending <= rising | (srqPending & ~serialPoll);
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  srqCause_a : assert property ($rose(srqPending) |-> $past(rising))
    else $error("request without enabled rising bit");
  pollClear_a : assert property (serialPoll && !rising |=> !srqPending)
    else $error("poll did not clear request");
  srqSteady_a : assert property (enabledNow == enabledPrev && !serialPoll |=> srqPending == $past(srqPending))
    else $error("request changed without cause");
  cover property (rising ##1 serialPoll);

endmodule : ser_srq_gen

// ==== rtl/ser_status_reporting.sv ====
// Status reporting hierarchy: event latches, summary byte, service request
`timescale 1ns/1ps
`include "ser_cfg.svh"

module ser_status_reporting
  import ser_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        storageBusy,
  input  wire logic        cmdExecuting,
  input  wire logic        outBufNotEmpty,
  input  wire logic        rxOverflow,
  input  wire logic        txOverflow,
  input  wire logic        execError,
  input  wire logic        illegalCmd,
  input  wire logic        userRequest,
  input  wire logic        refUnlock,
  input  wire logic        refFreqRange,
  input  wire logic        storageTrigger,
  input  wire logic        inputOverload,
  input  wire logic        ifAmpOverload,
  input  wire logic        filterOverload,
  input  wire logic        refFreqChanged,
  input  wire logic        chanOneOverload,
  input  wire logic        chanTwoOverload,
  input  wire logic        auxOverload,
  input  wire logic        ratioUnderflow,
  input  wire logic        batteryFail,
  input  wire logic        ramTestFail,
  input  wire logic        logicTestFail,
  input  wire logic        romTestFail,
  input  wire logic        fastXferAbort,
  input  wire logic        dspTestFail,
  input  wire logic        mathError,
  input  wire logic        clearStatus,
  input  wire logic        queryStrobe,
  input  wire ser_sel_t    queryTarget,
  input  wire logic        queryBitMode,
  input  wire logic [3:0]  queryBitIdx,
  input  wire logic        enWrite,
  input  wire ser_sel_t    enTarget,
  input  wire logic        enBitMode,
  input  wire logic [3:0]  enBitIdx,
  input  wire logic [15:0] enValue,
  input  wire logic        serialPoll,
  output logic [15:0]      queryData,
  output logic             queryValid,
  output logic [7:0]       pollData,
  output logic             pollValid,
  output logic             serviceRequest,
  output logic             queueFlush
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] bitMask(input logic [3:0] idx);
    bitMask = 16'h0001 << idx;
  endfunction : bitMask

  // Whole write or one-bit write of an enable register
  function automatic logic [15:0] applyEnable(
    input logic [15:0] old,
    input logic        bitMode,
    input logic [3:0]  idx,
    input logic [15:0] val
  );
    logic [15:0] m;
    m = bitMask(idx);
    if (bitMode)
      applyEnable = val[0] ? (old | m) : (old & ~m);
    else
      applyEnable = val;
  endfunction : applyEnable

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [7:0]  esrSet;
  logic [15:0] measSet;
  logic [7:0]  errSet;
  logic [15:0] queryMask;
  logic [15:0] esrClr;
  logic [15:0] measClr;
  logic [15:0] errClr;
  logic [7:0]  esrLatch;
  logic [15:0] measLatch;
  logic [7:0]  errLatch;
  logic [7:0]  eventEnable;
  logic [15:0] measEnable;
  logic [7:0]  errEnable;
  logic [7:0]  pollEnable;
  logic [7:0]  statusByte;
  logic [7:0]  next_statusByte;
  logic [15:0] next_queryData;
  logic [15:0] selValue;
  logic        masterSummary;
  logic        powerOnPending;
  logic        srqPending;
  logic [15:0] eventEnableWr;
  logic [15:0] errEnableWr;
  logic [15:0] pollEnableWr;

  // ---------------------------------------------------------------
  // Event inputs onto bit positions
  // ---------------------------------------------------------------
  // Power-on is seen once, right after reset release
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      powerOnPending <= 1'b1;
    else
      powerOnPending <= 1'b0;
  end

  always_comb
  begin
    esrSet = 8'h00;
    esrSet[`SER_ESR_RX_OVERFLOW]     = rxOverflow;
    esrSet[`SER_ESR_TX_OVERFLOW]     = txOverflow;
    esrSet[`SER_ESR_EXECUTION_ERROR] = execError;
    esrSet[`SER_ESR_ILLEGAL_CMD]     = illegalCmd;
    esrSet[`SER_ESR_USER_REQUEST]    = userRequest;
    esrSet[`SER_ESR_POWER_ON_EVENT]  = powerOnPending;
  end

  always_comb
  begin
    measSet = 16'h0000;
    measSet[`SER_MEAS_REF_UNLOCK]        = refUnlock;
    measSet[`SER_MEAS_REF_FREQ_RANGE]    = refFreqRange;
    measSet[`SER_MEAS_STORAGE_TRIGGER]   = storageTrigger;
    measSet[`SER_MEAS_INPUT_OVERLOAD]    = inputOverload;
    measSet[`SER_MEAS_IF_AMP_OVERLOAD]   = ifAmpOverload;
    measSet[`SER_MEAS_FILTER_OVERLOAD]   = filterOverload;
    measSet[`SER_MEAS_REF_FREQ_CHANGED]  = refFreqChanged;
    measSet[`SER_MEAS_CHAN_ONE_OVERLOAD] = chanOneOverload;
    measSet[`SER_MEAS_CHAN_TWO_OVERLOAD] = chanTwoOverload;
    measSet[`SER_MEAS_AUX_OVERLOAD]      = auxOverload;
    measSet[`SER_MEAS_RATIO_UNDERFLOW]   = ratioUnderflow;
  end

  always_comb
  begin
    errSet = 8'h00;
    errSet[`SER_ERR_BATTERY_FAIL]    = batteryFail;
    errSet[`SER_ERR_RAM_TEST_FAIL]   = ramTestFail;
    errSet[`SER_ERR_LOGIC_TEST_FAIL] = logicTestFail;
    errSet[`SER_ERR_ROM_TEST_FAIL]   = romTestFail;
    errSet[`SER_ERR_FAST_XFER_ABORT] = fastXferAbort;
    errSet[`SER_ERR_DSP_TEST_FAIL]   = dspTestFail;
    errSet[`SER_ERR_MATH_ERROR]      = mathError;
  end

  // ---------------------------------------------------------------
  // Clear on read and clear-status
  // ---------------------------------------------------------------
  assign queryMask = queryBitMode ? bitMask(queryBitIdx) : 16'hFFFF;

  assign esrClr  = clearStatus ? 16'hFFFF :
                   (queryStrobe && queryTarget == SEL_ESR)  ? queryMask : 16'h0000;
  assign measClr = clearStatus ? 16'hFFFF :
                   (queryStrobe && queryTarget == SEL_MEAS) ? queryMask : 16'h0000;
  assign errClr  = clearStatus ? 16'hFFFF :
                   (queryStrobe && queryTarget == SEL_ERR)  ? queryMask : 16'h0000;

  // ---------------------------------------------------------------
  // Latched registers
  // ---------------------------------------------------------------
  ser_latch_reg #(.WIDTH(8), .USED(`SER_ESR_USED)) uEventLatch (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .setVec   (esrSet),
    .clearVec (esrClr[7:0]),
    .value    (esrLatch)
  );

  ser_latch_reg #(.WIDTH(16), .USED(`SER_MEAS_USED)) uMeasLatch (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .setVec   (measSet),
    .clearVec (measClr),
    .value    (measLatch)
  );

  ser_latch_reg #(.WIDTH(8), .USED(`SER_ERR_USED)) uErrLatch (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .setVec   (errSet),
    .clearVec (errClr[7:0]),
    .value    (errLatch)
  );

  // ---------------------------------------------------------------
  // Enable registers
  // ---------------------------------------------------------------
  // Clear-status leaves the enables alone
  assign eventEnableWr = applyEnable({8'h00, eventEnable}, enBitMode, enBitIdx, enValue);
  assign errEnableWr   = applyEnable({8'h00, errEnable}, enBitMode, enBitIdx, enValue);
  assign pollEnableWr  = applyEnable({8'h00, pollEnable}, enBitMode, enBitIdx, enValue);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      eventEnable <= 8'h00;
      measEnable  <= `SER_ENABLE_RESET;
      errEnable   <= 8'h00;
      pollEnable  <= 8'h00;
    end
    else if (enWrite)
    begin
      if (enTarget == SEL_ESE)
        eventEnable <= eventEnableWr[7:0];
      if (enTarget == SEL_MEAE)
        measEnable <= applyEnable(measEnable, enBitMode, enBitIdx, enValue);
      if (enTarget == SEL_ERRE)
        errEnable <= errEnableWr[7:0];
      if (enTarget == SEL_SRE)
        pollEnable <= pollEnableWr[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Summary byte
  // ---------------------------------------------------------------
  // Bit 6 is left low here; the request flag lives in the poll path
  always_comb
  begin
    next_statusByte = 8'h00;
    next_statusByte[`SER_STB_SCAN_IDLE]           = ~storageBusy;
    next_statusByte[`SER_STB_INTERFACE_READY]     = ~cmdExecuting;
    next_statusByte[`SER_STB_ERROR_SUMMARY]       = |(errLatch & errEnable);
    next_statusByte[`SER_STB_MEASUREMENT_SUMMARY] = |(measLatch & measEnable);
    next_statusByte[`SER_STB_MSG_AVAILABLE]       = outBufNotEmpty;
    next_statusByte[`SER_STB_EVENT_SUMMARY]       = |(esrLatch & eventEnable);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      statusByte <= 8'h00;
    else
      statusByte <= next_statusByte;
  end

  // Query view of bit 6: any enabled summary bit, independent of polls
  assign masterSummary = |(statusByte & pollEnable & `SER_STB_SRQ_SOURCES);

  // ---------------------------------------------------------------
  // Service request
  // ---------------------------------------------------------------
  ser_srq_gen uSrq (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .summaryBits (statusByte),
    .enableBits  (pollEnable),
    .serialPoll  (serialPoll),
    .srqPending  (srqPending)
  );

  assign serviceRequest = srqPending;

  // Poll answer carries the request flag, the rest untouched
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pollData  <= 8'h00;
      pollValid <= 1'b0;
    end
    else
    begin
      pollValid <= serialPoll;
      if (serialPoll)
        pollData <= {1'b0, srqPending, statusByte[5:0]};
    end
  end

  // ---------------------------------------------------------------
  // Queue flush
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      queueFlush <= 1'b0;
    else
      queueFlush <= rxOverflow | txOverflow;
  end

  // ---------------------------------------------------------------
  // Query answer
  // ---------------------------------------------------------------
  always_comb
  begin
    unique case (queryTarget)
      SEL_STB:  selValue = {8'h00, 1'b0, masterSummary, statusByte[5:0]};
      SEL_SRE:  selValue = {8'h00, pollEnable};
      SEL_ESR:  selValue = {8'h00, esrLatch};
      SEL_ESE:  selValue = {8'h00, eventEnable};
      SEL_MEAS: selValue = measLatch;
      SEL_MEAE: selValue = measEnable;
      SEL_ERR:  selValue = {8'h00, errLatch};
      SEL_ERRE: selValue = {8'h00, errEnable};
    endcase
  end

  always_comb
  begin
    if (queryBitMode)
      next_queryData = {15'h0000, selValue[queryBitIdx]};
    else
      next_queryData = selValue;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      queryData  <= 16'h0000;
      queryValid <= 1'b0;
    end
    else
    begin
      queryValid <= queryStrobe;
      if (queryStrobe)
        queryData <= next_queryData;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  scanIdle_a : assert property (!$past(rst) |-> statusByte[0] == !$past(storageBusy))
    else $error("scan idle bit wrong");
  ifReady_a : assert property (!$past(rst) |-> statusByte[1] == !$past(cmdExecuting))
    else $error("interface ready bit wrong");
  errSum_a : assert property (statusByte[2] == $past(|(errLatch & errEnable)))
    else $error("error summary wrong");
  measSum_a : assert property (statusByte[3] == $past(|(measLatch & measEnable)))
    else $error("measurement summary wrong");
  msgAvail_a : assert property (outBufNotEmpty |=> statusByte[4])
    else $error("message available missing");
  evtSum_a : assert property (statusByte[5] == $past(|(esrLatch & eventEnable)))
    else $error("event summary wrong");
  topBits_a : assert property (!statusByte[7] && !statusByte[6] && !pollData[7])
    else $error("unused summary bit set");
  rxOvf_a : assert property (rxOverflow |=> esrLatch[0] && queueFlush)
    else $error("input overflow not reported");
  txOvf_a : assert property (txOverflow |=> esrLatch[2] && queueFlush)
    else $error("output overflow not reported");
  pwrOn_a : assert property ($fell(powerOnPending) |-> esrLatch[7])
    else $error("power-on event missing");
  measHold_a : assert property (measLatch[5] && !clearStatus && !(queryStrobe && queryTarget == SEL_MEAS) |=> measLatch[5])
    else $error("measurement bit dropped");
  wholeRead_a : assert property (queryStrobe && queryTarget == SEL_ERR && !queryBitMode && errSet == 8'h00 && !clearStatus |=> errLatch == 8'h00)
    else $error("whole read did not clear");
  bitRead_a : assert property (queryStrobe && queryTarget == SEL_ESR && queryBitMode && queryBitIdx == 4'h4 && esrSet == 8'h00 |=> esrLatch[7:5] == $past(esrLatch[7:5]))
    else $error("bit read cleared others");
  unused_a : assert property (!esrLatch[1] && !esrLatch[3] && measLatch[15:12] == 4'h0 && !measLatch[2] && !errLatch[0])
    else $error("unused bit set");
  answer_a : assert property (queryStrobe |=> queryValid ##1 !queryValid || $past(queryStrobe))
    else $error("query answer timing");

  cover property (serviceRequest ##[1:4] serialPoll ##1 pollValid && pollData[6]);
  cover property (queryStrobe && queryTarget == SEL_MEAS && !queryBitMode && measLatch != 16'h0000);
  cover property (clearStatus && esrLatch != 8'h00);
  cover property (rxOverflow ##1 queueFlush);

endmodule : ser_status_reporting

// ==== testbench/ser_host_model.sv ====
// Host computer model: serial-polls the block after each service request
`timescale 1ns/1ps
module ser_host_model
  import ser_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       serviceRequest,
  input  wire logic       pollValid,
  input  wire logic [7:0] pollData,
  input  wire logic       slow,
  output logic            serialPoll,
  output logic [7:0]      lastPoll,
  output int              pollCnt
);
  // ----------------
  // Poll sequencer
  // ----------------
  // Slow mode lingers three cycles, as a busy host would
  int delay;
  always @(negedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      {serialPoll, lastPoll, pollCnt, delay} <= '0;
    end
    else
    begin
      serialPoll <= serviceRequest === 1'b1 && !serialPoll && delay >= (slow ? 3 : 0);
      delay <= (serviceRequest === 1'b1 && !serialPoll) ? delay + 1 : 0;
      if (pollValid === 1'b1)
      begin
        lastPoll <= pollData;
        pollCnt <= pollCnt + 1;
      end
    end
  end
endmodule : ser_host_model

// ==== testbench/ser_status_reporting_tb_top.sv ====
// Self-checking bench of the status reporting block
`timescale 1ns/1ps
module ser_status_reporting_tb_top
  import ser_pkg::*;
;
  // ----------------
  // Stimulus, outputs, counters and access tasks
  // ----------------
  logic        ref_clk = 1'b0, rst = 1'b1, slow = 1'b0, clearStatus = 1'b0;
  logic        storageBusy = 1'b0, cmdExecuting = 1'b0, outBufNotEmpty = 1'b1;
  logic        queryStrobe = 1'b0, queryBitMode = 1'b0, enWrite = 1'b0, enBitMode = 1'b0;
  ser_sel_t    queryTarget = SEL_STB, enTarget = SEL_STB;
  logic [3:0]  queryBitIdx = 4'h0, enBitIdx = 4'h0;
  logic [15:0] enValue = 16'h0000, queryData;
  logic [4:0]  evIn = 5'h00;
  logic [10:0] measIn = 11'h000;
  logic [6:0]  errIn = 7'h00;
  logic [7:0]  pollData, lastPoll;
  logic        queryValid, pollValid, serviceRequest, queueFlush, serialPoll;
  int          pollCnt, error_cnt = 0, n_checks = 0;
  always #10 ref_clk = ~ref_clk;
  ser_status_reporting ser_status_reporting_inst (
    .ref_clk, .rst, .storageBusy, .cmdExecuting, .outBufNotEmpty, .rxOverflow(evIn[0]),
    .txOverflow(evIn[1]), .execError(evIn[2]), .illegalCmd(evIn[3]), .userRequest(evIn[4]),
    .refUnlock(measIn[0]), .refFreqRange(measIn[1]), .storageTrigger(measIn[2]),
    .inputOverload(measIn[3]), .ifAmpOverload(measIn[4]), .filterOverload(measIn[5]),
    .refFreqChanged(measIn[6]), .chanOneOverload(measIn[7]), .chanTwoOverload(measIn[8]),
    .auxOverload(measIn[9]), .ratioUnderflow(measIn[10]), .batteryFail(errIn[0]),
    .ramTestFail(errIn[1]), .logicTestFail(errIn[2]), .romTestFail(errIn[3]),
    .fastXferAbort(errIn[4]), .dspTestFail(errIn[5]), .mathError(errIn[6]), .clearStatus,
    .queryStrobe, .queryTarget, .queryBitMode, .queryBitIdx, .enWrite, .enTarget,
    .enBitMode, .enBitIdx, .enValue, .serialPoll, .queryData, .queryValid, .pollData,
    .pollValid, .serviceRequest, .queueFlush);
  ser_host_model ser_host_model_inst (.ref_clk, .rst, .serviceRequest, .pollValid,
    .pollData, .slow, .serialPoll, .lastPoll, .pollCnt);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  // Answer is awaited under a bound; a missing one ends the run
  task automatic query(input ser_sel_t t, input logic b, input logic [3:0] i,
                       input logic [15:0] exp);
    @(negedge ref_clk);
    {queryStrobe, queryTarget, queryBitMode, queryBitIdx} = {1'b1, t, b, i};
    @(negedge ref_clk);
    queryStrobe = 1'b0;
    for (int k = 0; k < 4 && queryValid !== 1'b1; k++)
      @(negedge ref_clk);
    chk({15'h0000, queryValid}, 16'h0001);
    if (queryValid !== 1'b1)
      final_report;
    chk(queryData, exp);
  endtask : query
  task automatic en(input ser_sel_t t, input logic [15:0] v);
    @(negedge ref_clk);
    {enWrite, enTarget, enValue} = {1'b1, t, v};
    @(negedge ref_clk);
    enWrite = 1'b0;
  endtask : en
  task automatic pulse(input logic [4:0] e, input logic [10:0] m, input logic [6:0] r);
    @(negedge ref_clk);
    {evIn, measIn, errIn} = {e, m, r};
    @(negedge ref_clk);
    {evIn, measIn, errIn} = '0;
  endtask : pulse
  task automatic waitPoll(input int n);
    for (int k = 0; k < 20 && pollCnt != n; k++)
      @(negedge ref_clk);
    chk(16'(pollCnt), 16'(n));
    if (pollCnt != n)
      final_report;
  endtask : waitPoll
  initial
  begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    query(SEL_ESR, 1'b0, 4'h0, 16'h0080);
    query(SEL_ESR, 1'b0, 4'h0, 16'h0000);
    pulse(5'h1F, 11'h000, 7'h00);
    chk({15'h0000, queueFlush}, 16'h0001);
    query(SEL_ESR, 1'b0, 4'h0, 16'h0075);
    pulse(5'h00, 11'h7FF, 7'h00);
    query(SEL_MEAS, 1'b1, 4'h2, 16'h0000);
    query(SEL_MEAS, 1'b1, 4'hB, 16'h0001);
    query(SEL_MEAS, 1'b0, 4'h0, 16'h07FB);
    pulse(5'h00, 11'h000, 7'h7F);
    @(negedge ref_clk);
    clearStatus = 1'b1;
    @(negedge ref_clk);
    clearStatus = 1'b0;
    query(SEL_ERR, 1'b0, 4'h0, 16'h0000);
    pulse(5'h00, 11'h000, 7'h7F);
    query(SEL_ERR, 1'b0, 4'h0, 16'h00FE);
    query(SEL_STB, 1'b0, 4'h0, 16'h0013);
    {storageBusy, cmdExecuting, outBufNotEmpty} = 3'b110;
    query(SEL_STB, 1'b0, 4'h0, 16'h0000);
    en(SEL_MEAE, 16'h0020);
    en(SEL_SRE, 16'h0008);
    pulse(5'h00, 11'h010, 7'h00);
    waitPoll(1);
    chk({8'h00, lastPoll}, 16'h0048);
    chk({15'h0000, serviceRequest}, 16'h0000);
    query(SEL_STB, 1'b0, 4'h0, 16'h0048);
    pulse(5'h00, 11'h010, 7'h00);
    repeat (6) @(negedge ref_clk);
    chk({15'h0000, serviceRequest}, 16'h0000);
    query(SEL_MEAS, 1'b0, 4'h0, 16'h0020);
    query(SEL_STB, 1'b0, 4'h0, 16'h0000);
    slow = 1'b1;
    pulse(5'h00, 11'h010, 7'h00);
    waitPoll(2);
    query(SEL_MEAS, 1'b0, 4'h0, 16'h0020);
    en(SEL_ESE, 16'h0010);
    en(SEL_ERRE, 16'h0080);
    en(SEL_SRE, 16'h0024);
    pulse(5'h04, 11'h000, 7'h40);
    waitPoll(3);
    chk({8'h00, lastPoll}, 16'h0064);
    query(SEL_SRE, 1'b1, 4'h5, 16'h0001);
    final_report;
  end
endmodule : ser_status_reporting_tb_top
